/* File: verilog/ebcs_pkg.sv */
// constants and carrier types of the external bus cycle sequencer
// assumes one system clock; all phase lengths count system clock periods
package ebcs_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CS_NUM = 4;
    localparam int CS_W   = 2;
    localparam int LEN_W  = 6;

    // phase length figures in clock units
    localparam logic [LEN_W-1:0] LEN_ZERO = 6'h00;
    localparam logic [LEN_W-1:0] LEN_ONE  = 6'h01;
    localparam logic [LEN_W-1:0] AB_SHORT = 6'h01;
    localparam logic [LEN_W-1:0] AB_LONG  = 6'h02;

    // bus cycle phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_SETUP,
        PH_ACCESS,
        PH_WAIT,
        PH_HOLD
    } ebcs_phase_e;

    // timing and mode of one chip select window
    typedef struct packed {
        logic       muxMode;               // shared address/data lines
        logic       readyEnable;           // access stretched by ready
        logic       readyActiveHigh;       // ready polarity
        logic       readyAsync;            // extra sync stage on ready
        logic       addressSetupPhaseLen;  // 0: one unit, 1: two units
        logic [1:0] windowChangeExt;       // extra units on window change
        logic [1:0] commandDelayPhaseLen;  // 0..3 units
        logic       writeSetupTurnaroundLen; // 0..1 unit
        logic [4:0] accessPhaseLen;        // units minus one, 1..32
        logic [1:0] holdPhaseLen;          // 0..3 units
    } ebcs_cs_cfg_s;

    // one bus cycle request from the core side
    typedef struct packed {
        logic              write;
        logic [CS_W-1:0]   cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        byteEn;   // bit1 upper byte, bit0 lower byte
    } ebcs_req_s;

    // registered bus pin outputs
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CS_NUM-1:0] csN;
        logic              rdN;
        logic              wrLowN;
        logic              wrHighN;
        logic              upperByteEnableN;
        logic              ale;
        logic [DATA_W-1:0] dataOut;
        logic              dataOutEnN;
    } ebcs_pins_s;

    localparam logic [CS_NUM-1:0] CS_NONE = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    localparam ebcs_pins_s PINS_IDLE = '{
        addr: ADDR_RST, csN: CS_NONE, rdN: 1'b1, wrLowN: 1'b1,
        wrHighN: 1'b1, upperByteEnableN: 1'b1, ale: 1'b0,
        dataOut: DATA_RST, dataOutEnN: 1'b1};

endpackage

/* File: verilog/ebcs_sync.sv */
// two-flop synchroniser for a level from outside the clock domain
// assumes the input may change at any time relative to clk
`timescale 1ns/100ps
`default_nettype none
module ebcs_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic levelIn,
    output logic      levelOut
);
    logic meta_q;
    logic stable_q;

    // first flop feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= 1'b0;
            stable_q <= 1'b0;
        end else begin
            meta_q   <= levelIn;
            stable_q <= meta_q;
        end
    end

    assign levelOut = stable_q;
endmodule
`default_nettype wire

/* File: verilog/ebcs_phase_timer.sv */
// down counter timing the length of one bus cycle phase
// assumes load on phase entry with a length of at least one
`timescale 1ns/100ps
`default_nettype none
module ebcs_phase_timer (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       load,
    input  wire logic [ebcs_pkg::LEN_W-1:0] loadVal,
    output logic                            done
);
    logic [ebcs_pkg::LEN_W-1:0] count_q;

    // count down once per clock unit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= ebcs_pkg::LEN_ZERO;
        end else if (load) begin
            count_q <= loadVal;
        end else if (count_q != ebcs_pkg::LEN_ZERO) begin
            count_q <= count_q - ebcs_pkg::LEN_ONE;
        end
    end

    // last unit of the phase
    assign done = (count_q <= ebcs_pkg::LEN_ONE);
endmodule
`default_nettype wire

/* File: verilog/ebcs_sequencer.sv */
// external bus cycle sequencer: runs six-phase bus cycles to external
// memories with per-window timing and an optional ready handshake
// assumes a static per-window config and one request at a time
`timescale 1ns/100ps
`default_nettype none
module ebcs_sequencer (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire ebcs_pkg::ebcs_cs_cfg_s [ebcs_pkg::CS_NUM-1:0]
                                            chipSelectPhaseTimingCfg,
    input  wire logic                       highSpeedDriverEn,
    input  wire logic                       reqValid,
    output logic                            reqReady,
    input  wire ebcs_pkg::ebcs_req_s        reqIn,
    output logic                            rspValid,
    output logic [ebcs_pkg::DATA_W-1:0]     rspData,
    output logic                            busBusy,
    output logic                            handshakeWaitState,
    output logic                            externalClockPinOut,
    output ebcs_pkg::ebcs_pins_s            busPins,
    input  wire logic [ebcs_pkg::DATA_W-1:0] dataIn,
    input  wire logic                       readyIn
);
    ebcs_pkg::ebcs_phase_e      state_q;
    ebcs_pkg::ebcs_phase_e      state_d;
    ebcs_pkg::ebcs_req_s        cur_q;
    ebcs_pkg::ebcs_req_s        nextReq;
    ebcs_pkg::ebcs_cs_cfg_s     cfg;
    ebcs_pkg::ebcs_cs_cfg_s     newCfg;
    ebcs_pkg::ebcs_pins_s       pins_q;
    ebcs_pkg::ebcs_pins_s       pins_d;
    logic [ebcs_pkg::CS_W-1:0]  lastCs_q;
    logic                       lastValid_q;
    logic [ebcs_pkg::DATA_W-1:0] rspData_q;
    logic                       rspValid_q;
    logic                       readySync;
    logic                       readyLate_q;
    logic                       readyLevel;
    logic                       readyActive;
    logic                       windowChange;
    logic                       accept;
    logic                       finish;
    logic                       timerLoad;
    logic                       timerDone;
    logic [ebcs_pkg::LEN_W-1:0] timerVal;

    // length in units of a given phase for a given window config
    function automatic logic [ebcs_pkg::LEN_W-1:0] phaseLen(
        input ebcs_pkg::ebcs_phase_e  ph,
        input ebcs_pkg::ebcs_cs_cfg_s c,
        input logic                   ext
    );
        logic [ebcs_pkg::LEN_W-1:0] len;
        len = ebcs_pkg::LEN_ZERO;
        unique case (ph)
            ebcs_pkg::PH_ADDR: begin
                len = c.addressSetupPhaseLen ? ebcs_pkg::AB_LONG
                                             : ebcs_pkg::AB_SHORT;
                if (ext) begin
                    len = len + {4'h0, c.windowChangeExt};
                end
            end
            ebcs_pkg::PH_CMD:
                len = {4'h0, c.commandDelayPhaseLen};
            ebcs_pkg::PH_SETUP:
                len = {5'h00, c.writeSetupTurnaroundLen};
            ebcs_pkg::PH_ACCESS:
                len = {1'b0, c.accessPhaseLen} + ebcs_pkg::LEN_ONE;
            ebcs_pkg::PH_HOLD:
                len = {4'h0, c.holdPhaseLen};
            ebcs_pkg::PH_IDLE,
            ebcs_pkg::PH_WAIT:
                len = ebcs_pkg::LEN_ZERO;
        endcase
        return len;
    endfunction

    assign cfg    = chipSelectPhaseTimingCfg[cur_q.cs];
    assign newCfg = chipSelectPhaseTimingCfg[reqIn.cs];

    // window change since the previous cycle
    assign windowChange = !lastValid_q || (reqIn.cs != lastCs_q);

    // ready pin through two flops, async adds one more
    ebcs_sync u_readySync (
        .clk      (clk),
        .resetn   (resetn),
        .levelIn  (readyIn),
        .levelOut (readySync)
    );

    // extra stage for asynchronous ready
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readyLate_q <= 1'b0;
        end else begin
            readyLate_q <= readySync;
        end
    end

    assign readyLevel  = cfg.readyAsync ? readyLate_q : readySync;
    assign readyActive = (readyLevel == cfg.readyActiveHigh);

    // cycle end may chain straight into the next request
    always_comb begin
        reqReady = 1'b0;
        unique case (state_q)
            ebcs_pkg::PH_IDLE:
                reqReady = 1'b1;
            ebcs_pkg::PH_HOLD:
                reqReady = timerDone;
            ebcs_pkg::PH_ACCESS,
            ebcs_pkg::PH_WAIT:
                reqReady = finish && (cfg.holdPhaseLen == 2'h0);
            ebcs_pkg::PH_ADDR,
            ebcs_pkg::PH_CMD,
            ebcs_pkg::PH_SETUP:
                reqReady = 1'b0;
        endcase
    end

    assign accept = reqValid && reqReady;

    // timer ends access, gated by ready when enabled; ready alone ends wait
    always_comb begin
        finish = 1'b0;
        if (state_q == ebcs_pkg::PH_ACCESS) begin
            finish = timerDone && (!cfg.readyEnable || readyActive);
        end else if (state_q == ebcs_pkg::PH_WAIT) begin
            finish = readyActive;
        end
    end

    // phase order with zero-length phases skipped
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ebcs_pkg::PH_IDLE:
                state_d = ebcs_pkg::PH_IDLE;
            ebcs_pkg::PH_ADDR:
                if (timerDone) begin
                    if (cfg.commandDelayPhaseLen != 2'h0) begin
                        state_d = ebcs_pkg::PH_CMD;
                    end else if (cfg.writeSetupTurnaroundLen) begin
                        state_d = ebcs_pkg::PH_SETUP;
                    end else begin
                        state_d = ebcs_pkg::PH_ACCESS;
                    end
                end
            ebcs_pkg::PH_CMD:
                if (timerDone) begin
                    state_d = cfg.writeSetupTurnaroundLen
                            ? ebcs_pkg::PH_SETUP : ebcs_pkg::PH_ACCESS;
                end
            ebcs_pkg::PH_SETUP:
                if (timerDone) begin
                    state_d = ebcs_pkg::PH_ACCESS;
                end
            ebcs_pkg::PH_ACCESS:
                if (timerDone && !finish) begin
                    state_d = ebcs_pkg::PH_WAIT;
                end
            ebcs_pkg::PH_WAIT:
                state_d = ebcs_pkg::PH_WAIT;
            ebcs_pkg::PH_HOLD:
                if (timerDone) begin
                    state_d = ebcs_pkg::PH_IDLE;
                end
        endcase
        if (finish) begin
            state_d = (cfg.holdPhaseLen == 2'h0)
                    ? ebcs_pkg::PH_IDLE : ebcs_pkg::PH_HOLD;
        end
        if (accept) begin
            state_d = ebcs_pkg::PH_ADDR;
        end
    end

    // phase timer loads on every phase entry
    assign timerLoad = accept || (state_d != state_q);
    assign timerVal  = accept ? phaseLen(ebcs_pkg::PH_ADDR, newCfg,
                                         windowChange)
                              : phaseLen(state_d, cfg, 1'b0);

    ebcs_phase_timer u_timer (
        .clk     (clk),
        .resetn  (resetn),
        .load    (timerLoad),
        .loadVal (timerVal),
        .done    (timerDone)
    );

    // phase state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ebcs_pkg::PH_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // request held for the running cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_q       <= '0;
            lastCs_q    <= '0;
            lastValid_q <= 1'b0;
        end else if (accept) begin
            cur_q       <= reqIn;
            lastCs_q    <= reqIn.cs;
            lastValid_q <= 1'b1;
        end
    end

    assign nextReq = accept ? reqIn : cur_q;

    // pin levels for the phase entered at the next edge
    always_comb begin
        logic mux;
        logic inCmd;
        logic active;
        mux    = accept ? newCfg.muxMode : cfg.muxMode;
        inCmd  = (state_d == ebcs_pkg::PH_ACCESS)
              || (state_d == ebcs_pkg::PH_WAIT);
        active = (state_d != ebcs_pkg::PH_IDLE);
        pins_d = pins_q;
        pins_d.rdN        = 1'b1;
        pins_d.wrLowN     = 1'b1;
        pins_d.wrHighN    = 1'b1;
        pins_d.ale        = 1'b0;
        pins_d.csN        = ebcs_pkg::CS_NONE;
        pins_d.dataOutEnN = 1'b1;
        pins_d.upperByteEnableN = 1'b1;
        if (active) begin
            pins_d.addr = nextReq.addr;
            pins_d.csN[nextReq.cs] = 1'b0;
            pins_d.upperByteEnableN = !nextReq.byteEn[1];
            pins_d.dataOut = nextReq.wdata;
            if (inCmd) begin
                pins_d.rdN     = nextReq.write;
                pins_d.wrLowN  = !(nextReq.write && nextReq.byteEn[0]);
                pins_d.wrHighN = !(nextReq.write && nextReq.byteEn[1]);
            end
            // write data from setup through hold
            if (nextReq.write && (state_d != ebcs_pkg::PH_ADDR)
                && (state_d != ebcs_pkg::PH_CMD)) begin
                pins_d.dataOutEnN = 1'b0;
            end
        end
        if (mux && ((state_d == ebcs_pkg::PH_ADDR)
                    || (state_d == ebcs_pkg::PH_CMD))) begin
            pins_d.dataOut    = nextReq.addr[ebcs_pkg::DATA_W-1:0];
            pins_d.dataOutEnN = 1'b0;
            pins_d.ale        = (state_d == ebcs_pkg::PH_ADDR);
        end
    end

    // pin registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins_q <= ebcs_pkg::PINS_IDLE;
        end else begin
            pins_q <= pins_d;
        end
    end

    // read data latched as the read strobe rises
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rspData_q  <= ebcs_pkg::DATA_RST;
            rspValid_q <= 1'b0;
        end else begin
            rspValid_q <= finish;
            if (finish && !cur_q.write) begin
                rspData_q <= dataIn;
            end
        end
    end

    // status taken from the phase state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busBusy            <= 1'b0;
            handshakeWaitState <= 1'b0;
        end else begin
            busBusy            <= (state_d != ebcs_pkg::PH_IDLE);
            handshakeWaitState <= (state_d == ebcs_pkg::PH_WAIT);
        end
    end

    // system clock to the pin when its driver is on
    assign externalClockPinOut = highSpeedDriverEn ? clk : 1'b0;

    assign busPins  = pins_q;
    assign rspValid = rspValid_q;
    assign rspData  = rspData_q;
endmodule
`default_nettype wire

/* File: tb/ebcs_sequencer_properties.sv */
// assertions on the sequencer's bus pins and core handshake
// assumes binding onto ebcs_sequencer, seeing its ports only
`timescale 1ns/100ps
`default_nettype none
module ebcs_sequencer_properties (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 reqValid,
    input wire logic                 reqReady,
    input wire logic                 rspValid,
    input wire logic                 busBusy,
    input wire logic                 handshakeWaitState,
    input wire logic                 highSpeedDriverEn,
    input wire logic                 externalClockPinOut,
    input wire ebcs_pkg::ebcs_pins_s busPins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // strobe summary
    wire logic rdLow = !busPins.rdN;
    wire logic wrLow = !busPins.wrLowN || !busPins.wrHighN;

    property p_take_addr;
        reqValid && reqReady |=> busPins.csN != ebcs_pkg::CS_NONE
            && !rdLow && !wrLow;
    endproperty
    a_take_addr: assert property (p_take_addr)
        else $error("no address phase after take");
    property p_rd_end;
        $rose(busPins.rdN) |-> rspValid;
    endproperty
    a_rd_end: assert property (p_rd_end)
        else $error("read strobe ended without response");
    property p_rsp_pulse;
        rspValid |=> !rspValid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response longer than one cycle");
    property p_addr_first;
        $fell(busPins.rdN) |-> $past(busPins.csN) != ebcs_pkg::CS_NONE;
    endproperty
    a_addr_first: assert property (p_addr_first)
        else $error("read strobe without address setup");
    property p_ale_addr;
        busPins.ale |-> !busPins.dataOutEnN && !rdLow && !wrLow
            && busPins.dataOut == busPins.addr[15:0];
    endproperty
    a_ale_addr: assert property (p_ale_addr)
        else $error("latch strobe without address on data lines");
    property p_wait_strobe;
        handshakeWaitState |-> rdLow || wrLow;
    endproperty
    a_wait_strobe: assert property (p_wait_strobe)
        else $error("wait state outside access");
    property p_upper;
        !busPins.wrHighN |-> !busPins.upperByteEnableN;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper write without upper byte enable");
    property p_access_stable;
        rdLow && $past(rdLow) |-> $stable(busPins.addr)
            && $stable(busPins.csN);
    endproperty
    a_access_stable: assert property (p_access_stable)
        else $error("address moved during read access");
    property p_busy;
        rdLow || wrLow |-> busBusy;
    endproperty
    a_busy: assert property (p_busy)
        else $error("strobe while not busy");
    property p_clock_out;
        @(negedge clk) disable iff (!resetn)
            externalClockPinOut == highSpeedDriverEn;
    endproperty
    a_clock_out: assert property (p_clock_out)
        else $error("reference clock not following driver enable");
    // main scenarios reached
    c_read_end: cover property ($rose(busPins.rdN));
    c_ale: cover property (busPins.ale);
    c_wait: cover property (handshakeWaitState);
endmodule
bind ebcs_sequencer ebcs_sequencer_properties u_props (
    .clk, .resetn, .reqValid, .reqReady, .rspValid, .busBusy,
    .handshakeWaitState, .highSpeedDriverEn, .externalClockPinOut, .busPins
);
`default_nettype wire

/* File: tb/ebcs_mem_model.sv */
// behavioural external memory with a ready handshake
// assumes window 3 holds the asynchronous ready device
`timescale 1ns/100ps
`default_nettype none
module ebcs_mem_model (
    input  wire logic                 clk,
    input  wire logic                 linkClk,
    input  wire ebcs_pkg::ebcs_pins_s pins,
    input  wire logic                 readyHigh,
    input  wire logic [3:0]           readyDelay,
    output logic [15:0]               dataIn,
    output logic                      readyIn
);
    logic [15:0] mem [16];
    logic [15:0] lastQ = 16'h0000;
    logic [3:0]  cnt = 4'h0;
    logic        actSync = 1'b0;
    logic        actAsync = 1'b0;
    wire logic   strobe = !(pins.rdN && pins.wrLowN && pins.wrHighN);
    wire logic [3:0] idx = pins.addr[3:0];

    // known contents at start
    initial for (int i = 0; i < 16; i++) mem[i] = 16'(i * 16'h1111) ^ 16'hC3A5;
    always @(posedge clk) begin
        if (!pins.wrLowN) mem[idx][7:0] <= pins.dataOut[7:0];
        if (!pins.wrHighN) mem[idx][15:8] <= pins.dataOut[15:8];
        cnt <= !strobe ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
        lastQ <= dataIn;
    end
    // sync ready moves with the reference clock
    always @(negedge clk) actSync <= strobe && cnt > readyDelay;
    // async ready moves with the peripheral clock
    always @(posedge linkClk) actAsync <= strobe && cnt > readyDelay;
    assign readyIn = (!pins.csN[3] ? actAsync : actSync) ~^ readyHigh;
    // lines change once the read ends
    always_comb begin
        if (!pins.dataOutEnN) dataIn = pins.dataOut;
        else if (!pins.rdN) dataIn = mem[idx];
        else dataIn = ~lastQ;
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the external bus cycle sequencer
// assumes the memory model on the bus pins and a 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {
        logic        rd;
        logic [15:0] d;
        int          take;
        int          lo;
        int          hi;
    } ebcs_exp_s;

    logic                         clk = 1'b0;
    logic                         linkClk = 1'b0;
    logic                         resetn = 1'b0;
    logic                         highSpeedDriverEn = 1'b1;
    logic                         reqValid = 1'b0;
    logic                         reqReady, rspValid, busBusy, readyIn;
    logic                         handshakeWaitState, externalClockPinOut;
    logic [3:0]                   rdyDelay = 4'h0;
    logic [15:0]                  rspData, dataIn;
    logic [15:0]                  shadow [16];
    ebcs_pkg::ebcs_cs_cfg_s [3:0] cfg = '0;
    ebcs_pkg::ebcs_req_s          req = '0;
    ebcs_pkg::ebcs_pins_s         busPins;
    ebcs_exp_s                    expQ[$];
    ebcs_exp_s                    got;
    int cyc = 0, err_total = 0, compares = 0, lastCs = -1, waitSeen = 0;

    always #2.5 clk = ~clk;
    // peripheral clock, unrelated phase
    initial #1.3 forever #24 linkClk = ~linkClk;

    ebcs_sequencer dut (
        .clk, .resetn, .chipSelectPhaseTimingCfg(cfg), .highSpeedDriverEn,
        .reqValid, .reqReady, .reqIn(req), .rspValid, .rspData, .busBusy,
        .handshakeWaitState, .externalClockPinOut, .busPins, .dataIn,
        .readyIn
    );
    ebcs_mem_model mem (
        .clk, .linkClk, .pins(busPins), .readyHigh(cfg[2].readyActiveHigh),
        .readyDelay(rdyDelay), .dataIn, .readyIn
    );

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] expd);
        compares++;
        if (seen !== expd) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", what, expd, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n = 0;
        while (expQ.size() != 0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic issue(input logic wr, input logic [1:0] cs);
        ebcs_exp_s x;
        logic [23:0] a;
        logic [15:0] w;
        logic [1:0] be;
        int b, e;
        a = 24'($urandom);
        w = 16'($urandom);
        be = 2'($urandom_range(1, 3));
        if (cfg[cs].readyEnable) begin
            reqValid = 1'b0;
            wait_idle();
            repeat (14) @(negedge clk);
        end
        b = cfg[cs].addressSetupPhaseLen + cfg[cs].commandDelayPhaseLen
            + cfg[cs].writeSetupTurnaroundLen + cfg[cs].accessPhaseLen + 3;
        if (cs != lastCs) b += cfg[cs].windowChangeExt;
        lastCs = cs;
        x.lo = b;
        x.hi = b;
        if (cfg[cs].readyEnable) begin
            e = b - cfg[cs].accessPhaseLen + 1 + rdyDelay
                + (cfg[cs].readyAsync ? 3 : 2);
            x.lo = e - 1 > b ? e - 1 : b;
            x.hi = (e + 1 > b ? e + 1 : b) + (cfg[cs].readyAsync ? 10 : 0);
        end
        x.rd = !wr;
        x.d = shadow[a[3:0]];
        if (wr && be[0]) shadow[a[3:0]][7:0] = w[7:0];
        if (wr && be[1]) shadow[a[3:0]][15:8] = w[15:8];
        req = '{write: wr, cs: cs, addr: a, wdata: w, byteEn: be};
        reqValid = 1'b1;
        #1;
        while (reqReady !== 1'b1) begin
            @(negedge clk);
            #1;
        end
        x.take = cyc; // cycle in which the request is taken
        expQ.push_back(x);
        @(negedge clk);
    endtask

    // cycle count and hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end

    // compare each finished cycle with the oldest note
    always @(negedge clk) begin
        if (resetn && handshakeWaitState === 1'b1) waitSeen++;
        if (resetn && rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unnoted response", 1'b1, 1'b0);
            end else begin
                got = expQ.pop_front();
                check("cycle length in window", cyc - got.take >= got.lo
                      && cyc - got.take <= got.hi, 1'b1);
                if (got.rd) check("read data", rspData, got.d);
            end
        end
    end

    // rounds of random windows and back-to-back requests
    initial begin
        void'($urandom(75));
        for (int i = 0; i < 16; i++) shadow[i] = 16'(i * 16'h1111) ^ 16'hC3A5;
        repeat (12) @(negedge clk);
        check("reset pins", busPins, ebcs_pkg::PINS_IDLE);
        check("reset request ready", reqReady, 1'b1);
        resetn = 1'b1;
        for (int r = 0; r < 24; r++) begin
            wait_idle();
            for (int k = 0; k < 4; k++) cfg[k] = 17'($urandom);
            cfg[0].readyEnable = 1'b0;
            cfg[0].muxMode = 1'b0;
            cfg[1].readyEnable = 1'b0;
            cfg[1].muxMode = 1'b1;
            cfg[2].readyEnable = 1'b1;
            cfg[2].readyAsync = 1'b0;
            cfg[3].readyEnable = 1'b1;
            cfg[3].readyAsync = 1'b1;
            cfg[3].readyActiveHigh = cfg[2].readyActiveHigh;
            if (r == 1) cfg[1].accessPhaseLen = 5'h1F;
            rdyDelay = 4'($urandom_range(0, 6));
            highSpeedDriverEn = r[0];
            if (r == 12) begin
                resetn = 1'b0;
                repeat (3) @(negedge clk);
                resetn = 1'b1;
                lastCs = -1;
            end
            repeat (14) @(negedge clk);
            for (int n = 0; n < 6; n++) issue(1'($urandom), 2'($urandom));
            reqValid = 1'b0;
        end
        wait_idle();
        check("notes left", expQ.size(), 0);
        check("wait states seen", waitSeen > 0, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
